/* File: inc/adcscr_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Functional notes
// - Byte top bit picks setup or configuration
// - Setup bits 6..4 reference select, reset 000
// - Setup bit 2 polarity, reset unipolar
// - Setup bit 1 zero resets configuration register
// - Don't-care bits have no effect
// - Configuration bits 6..5 scan select, reset 00
// - Configuration bit 1 channel select, reset 0
// - Configuration bit 0 input mode, reset single-ended
// - Single-ended converts selected input against ground
// - Differential polarity of inputs follows channel select
// - Single-ended always forces unipolar operation
// - Scan codes fixed; code 10 reserved
//////////////////////////////////////////////////////////////////////////////
package adcscr_pkg;
  localparam int unsigned REG_SEL_BIT = 7;
  localparam int unsigned REF_SEL_HI = 6;
  localparam int unsigned REF_SEL_LO = 4;
  localparam int unsigned CLK_SRC_BIT = 3;
  localparam int unsigned POLARITY_BIT = 2;
  localparam int unsigned CFG_RST_BIT = 1;
  localparam int unsigned SCAN_HI = 6;
  localparam int unsigned SCAN_LO = 5;
  localparam int unsigned CHAN_BIT = 1;
  localparam int unsigned MODE_BIT = 0;
  // Power-up values of stored fields
  localparam logic [2:0] REF_SEL_RST = 3'h0;
  localparam logic CLK_SRC_RST = 1'b0;
  localparam logic POLARITY_RST = 1'b0;
  localparam logic [1:0] SCAN_RST = 2'h0;
  localparam logic CHAN_RST = 1'b0;
  localparam logic MODE_RST = 1'b1;
  typedef enum logic [1:0] {
    ADCSCR_SCAN_UP = 2'h0,
    ADCSCR_SCAN_REPEAT8 = 2'h1,
    ADCSCR_SCAN_RESERVED = 2'h2,
    ADCSCR_SCAN_SINGLE = 2'h3
  } adcscr_scan_t;
  localparam logic [3:0] REPEAT_COUNT = 4'h8;
endpackage

/* File: inc/adcscr_cfg_if.sv */
// Configuration fields handed from the register file to the input routing
interface adcscr_cfg_if;
  logic channel_select;
  logic input_mode_select;
  logic polarity_select;
  modport src (output channel_select, output input_mode_select, output polarity_select);
  modport dst (input channel_select, input input_mode_select, input polarity_select);
endinterface

/* File: hdl/adcscr_route.sv */
// Resolves which analog input is positive, which negative, and polarity
module adcscr_route (
  adcscr_cfg_if.dst cfg,
  output logic pos_is_one,
  output logic neg_is_ground,
  output logic bipolar_active
);
  always_comb begin
    pos_is_one = cfg.channel_select;
    neg_is_ground = cfg.input_mode_select;
    bipolar_active = cfg.polarity_select & ~cfg.input_mode_select;
  end
endmodule // adcscr_route

/* File: hdl/adcscr_regs.sv */
module adcscr_regs (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  output logic [2:0] reference_select,
  output logic clock_source_select,
  output logic polarity_select,
  output logic [1:0] scan_select,
  output logic channel_select,
  output logic input_mode_select,
  output logic pos_is_one,
  output logic neg_is_ground,
  output logic bipolar_active,
  output logic [3:0] conversions_per_scan,
  output logic scan_code_illegal
);
  logic [2:0] ref_q;
  logic clk_src_q;
  logic pol_q;
  logic [1:0] scan_q;
  logic chan_q;
  logic mode_q;
  logic is_setup;
  logic cfg_reset;

  adcscr_cfg_if cfg_bus ();

  //////////////////////////////////////////////////////////////////////////////
  // Byte steering
  assign is_setup = wr_data[adcscr_pkg::REG_SEL_BIT];
  assign cfg_reset = wr_valid & is_setup & ~wr_data[adcscr_pkg::CFG_RST_BIT];

  //////////////////////////////////////////////////////////////////////////////
  // Setup register; bit 0 never stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= adcscr_pkg::REF_SEL_RST;
      clk_src_q <= adcscr_pkg::CLK_SRC_RST;
      pol_q <= adcscr_pkg::POLARITY_RST;
    end else if (wr_valid && is_setup) begin
      ref_q <= wr_data[adcscr_pkg::REF_SEL_HI:adcscr_pkg::REF_SEL_LO];
      clk_src_q <= wr_data[adcscr_pkg::CLK_SRC_BIT];
      pol_q <= wr_data[adcscr_pkg::POLARITY_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration register; bits 4..2 never stored
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      scan_q <= adcscr_pkg::SCAN_RST;
      chan_q <= adcscr_pkg::CHAN_RST;
      mode_q <= adcscr_pkg::MODE_RST;
    end else if (cfg_reset) begin
      scan_q <= adcscr_pkg::SCAN_RST;
      chan_q <= adcscr_pkg::CHAN_RST;
      mode_q <= adcscr_pkg::MODE_RST;
    end else if (wr_valid && !is_setup) begin
      scan_q <= wr_data[adcscr_pkg::SCAN_HI:adcscr_pkg::SCAN_LO];
      chan_q <= wr_data[adcscr_pkg::CHAN_BIT];
      mode_q <= wr_data[adcscr_pkg::MODE_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign reference_select = ref_q;
  assign clock_source_select = clk_src_q;
  assign polarity_select = pol_q;
  assign scan_select = scan_q;
  assign channel_select = chan_q;
  assign input_mode_select = mode_q;
  assign cfg_bus.channel_select = chan_q;
  assign cfg_bus.input_mode_select = mode_q;
  assign cfg_bus.polarity_select = pol_q;

  adcscr_route u_route (
    .cfg(cfg_bus),
    .pos_is_one(pos_is_one),
    .neg_is_ground(neg_is_ground),
    .bipolar_active(bipolar_active)
  );

  // Conversions per scan from the scan code
  always_comb begin
    conversions_per_scan = 4'h1;
    scan_code_illegal = 1'b0;
    unique case (adcscr_pkg::adcscr_scan_t'(scan_q))
      adcscr_pkg::ADCSCR_SCAN_UP: conversions_per_scan = {3'h0, chan_q} + 4'h1;
      adcscr_pkg::ADCSCR_SCAN_REPEAT8: conversions_per_scan = adcscr_pkg::REPEAT_COUNT;
      adcscr_pkg::ADCSCR_SCAN_RESERVED: scan_code_illegal = 1'b1;
      adcscr_pkg::ADCSCR_SCAN_SINGLE: conversions_per_scan = 4'h1;
    endcase
  end
endmodule // adcscr_regs

/* File: bench/adcscr_asserts.sv */
module adcscr_asserts (
  input wire logic clk,
  input wire logic rstn,
  input wire logic wr_valid,
  input wire logic [7:0] wr_data,
  input wire logic [2:0] reference_select,
  input wire logic clock_source_select,
  input wire logic polarity_select,
  input wire logic [1:0] scan_select,
  input wire logic channel_select,
  input wire logic input_mode_select,
  input wire logic pos_is_one,
  input wire logic neg_is_ground,
  input wire logic bipolar_active,
  input wire logic scan_code_illegal,
  input wire logic [3:0] conversions_per_scan
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence s_setup; wr_valid && wr_data[7]; endsequence
  sequence s_cfg; wr_valid && !wr_data[7]; endsequence
  a_ref_load: assert property (s_setup |=> reference_select == $past(wr_data[6:4])) else $error("ref");
  a_clk_pol_load: assert property (s_setup |=> {clock_source_select, polarity_select}
    == $past(wr_data[3:2])) else $error("clk pol");
  a_cfg_reset: assert property (s_setup ##0 !wr_data[1] |=>
    !scan_select && !channel_select && input_mode_select) else $error("cfg reset");
  a_cfg_kept: assert property (s_setup ##0 wr_data[1] |=>
    $stable({scan_select, channel_select, input_mode_select})) else $error("cfg kept");
  a_cfg_load: assert property (s_cfg |=> {scan_select, channel_select, input_mode_select} ==
    {$past(wr_data[6:5]), $past(wr_data[1:0])}) else $error("cfg load");
  a_regs_hold: assert property (!wr_valid |=>
    $stable({reference_select, clock_source_select, polarity_select,
    scan_select, channel_select, input_mode_select})) else $error("hold");
  a_input_route: assert property (pos_is_one == channel_select && neg_is_ground == input_mode_select)
    else $error("route");
  a_single_uni: assert property (input_mode_select |-> !bipolar_active) else $error("bipolar");
  a_repeat_count: assert property (scan_select == 2'h1 |-> conversions_per_scan == 4'h8)
    else $error("count");
endmodule // adcscr_asserts
bind adcscr_regs adcscr_asserts chk_u (.*);

/* File: bench/adcscr_master.sv */
module adcscr_master (
  input wire logic clk,
  output logic wr_valid,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    wr_valid = 1'b0;
    wr_data = 8'h00;
  end
  // One byte per call; sends any byte as given, reserved scan code included
  task automatic send(input logic [7:0] b);
    @(posedge clk) #1;
    wr_valid = 1'b1;
    wr_data = b;
    @(posedge clk) #1;
    wr_valid = 1'b0;
    wr_data = ~b;
  endtask
endmodule // adcscr_master

/* File: bench/tb_top.sv */
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic wr_valid, clock_source_select, polarity_select, channel_select, input_mode_select;
  logic pos_is_one, neg_is_ground, bipolar_active, scan_code_illegal;
  logic [7:0] wr_data;
  logic [2:0] reference_select;
  logic [1:0] scan_select;
  logic [3:0] conversions_per_scan;
  int n_errors = 0;
  int compares = 0;
  int cyc = 0;
  wire logic [16:0] seen = {reference_select, clock_source_select, polarity_select, scan_select, channel_select,
    input_mode_select, pos_is_one, neg_is_ground, bipolar_active, conversions_per_scan, scan_code_illegal};
  adcscr_regs dut_u (.*);
  adcscr_master m_u (.clk(clk), .wr_valid(wr_valid), .wr_data(wr_data));
  initial begin
    forever #20 clk = ~clk;
  end
  function automatic logic [16:0] ex(logic [2:0] r, logic c, p, logic [1:0] s, logic ch, m);
    logic [3:0] n;
    n = (s == 2'h0) ? {3'h0, ch} + 4'h1 : (s == 2'h1) ? 4'h8 : 4'h1;
    return {r, c, p, s, ch, m, ch, m, p & ~m, n, s == 2'h2};
  endfunction
  task automatic chk(input logic [16:0] s, e);
    compares++;
    if (s !== e) begin
      n_errors++;
      $display("mismatch t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task automatic close_out;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 300) begin
      n_errors++;
      close_out();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    chk(seen, ex(3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
    $display("reset test done");
    m_u.send(8'hfe);
    chk(seen, ex(3'h7, 1'b1, 1'b1, 2'h0, 1'b0, 1'b1));
    for (int i = 0; i < 4; i++) begin
      if (i != 2) begin
        m_u.send({1'b0, 2'(i), 5'h1e});
        chk(seen, ex(3'h7, 1'b1, 1'b1, 2'(i), 1'b1, 1'b0));
      end
    end
    $display("scan test done");
    m_u.send(8'h81);
    chk(seen, ex(3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
    m_u.send(8'h03);
    chk(seen, ex(3'h0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1));
    repeat (5) @(posedge clk);
    chk(seen, ex(3'h0, 1'b0, 1'b0, 2'h0, 1'b1, 1'b1));
    $display("reset byte test done");
    m_u.send(8'hfe);
    @(posedge clk) #1 rstn = 1'b0;
    @(posedge clk) #1 rstn = 1'b1;
    chk(seen, ex(3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 1'b1));
    $display("mid-run reset test done");
    close_out();
  end
endmodule // tb_top
